// ==== hw/siu_pkg.sv ====
// Constants, types and helper functions shared by the serial transceiver files.
package siu_pkg;

  localparam int CLK_HZ       = 10_000_000;
  localparam int BAUD_SLOW_HZ = 2400;
  localparam int BAUD_FAST_HZ = 9600;
  localparam int OVERSAMPLE   = 16;
  localparam int DATA_BITS    = 8;
  localparam int FIFO_WIDTH   = 8;
  localparam int FIFO_DEPTH   = 32;

  // Core clocks per oversampling phase; the fractional part is dropped, which keeps
  // the bit rate within one percent of nominal at both speeds.
  localparam logic [8:0] DIV_SLOW = 9'(CLK_HZ / (BAUD_SLOW_HZ * OVERSAMPLE));
  localparam logic [8:0] DIV_FAST = 9'(CLK_HZ / (BAUD_FAST_HZ * OVERSAMPLE));

  localparam logic [3:0] PH_VOTE_A = 4'h6;
  localparam logic [3:0] PH_VOTE_B = 4'h7;
  localparam logic [3:0] PH_VOTE_C = 4'h8;
  localparam logic [3:0] PH_LAST   = 4'hF;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL  = 1'b1;
  localparam logic IDLE_LEVEL  = 1'b1;

  localparam logic [8:0] DIV_RST   = 9'h000;
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [2:0] BIT_RST   = 3'h0;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [1:0] VOTE_RST  = 2'h0;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} siu_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} siu_rx_state_t;

  function automatic logic [8:0] siu_baud_div(input logic fast);
    siu_baud_div = fast ? DIV_FAST : DIV_SLOW;
  endfunction : siu_baud_div

  function automatic logic siu_maj3(input logic a, input logic b, input logic c);
    siu_maj3 = (a & b) | (a & c) | (b & c);
  endfunction : siu_maj3

  // True on the last core clock of one oversampling phase.
  function automatic logic siu_div_end(input logic [8:0] cnt, input logic [8:0] div);
    siu_div_end = (cnt >= (div - 9'h001));
  endfunction : siu_div_end

endpackage : siu_pkg

// ==== hw/siu_stream_if.sv ====
// Valid/ready byte stream between the transceiver's own modules.
`timescale 1ns/1ps
`default_nettype none
interface siu_stream_if #(
  parameter int WIDTH = 8
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : siu_stream_if
`default_nettype wire

// ==== hw/siu_fifo.sv ====
// Transmit FIFO with a registered read stage in front of its memory.
`timescale 1ns/1ps
`default_nettype none
module siu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic   core_clk,
  input wire logic   arst_n,
  siu_stream_if.snk  wrPort,
  siu_stream_if.src  rdPort
);
  // DEPTH must be a power of two so that the pointers wrap by themselves.
  localparam int             PTR_W      = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W:0] ONE_COUNT  = (PTR_W + 1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtrReg;
  logic [PTR_W-1:0] rdPtrReg;
  logic [PTR_W:0]   countReg;
  logic [PTR_W:0]   countNext;
  logic [WIDTH-1:0] outDataReg;
  logic             outValidReg;
  logic             outValidNext;
  wire              wrFire;
  wire              rdFire;
  wire              loadOut;

  assign wrPort.ready = (countReg != FULL_COUNT);
  assign wrFire       = wrPort.valid & wrPort.ready;
  assign rdFire       = outValidReg & rdPort.ready;
  assign loadOut      = (countReg != '0) & (~outValidReg | rdPort.ready);
  assign rdPort.valid = outValidReg;
  assign rdPort.data  = outDataReg;

  assign outValidNext = loadOut ? 1'b1 : (rdFire ? 1'b0 : outValidReg);
  assign countNext    = countReg + (wrFire ? ONE_COUNT : '0) - (loadOut ? ONE_COUNT : '0);

  always_ff @(posedge core_clk) begin
    if (wrFire) begin
      mem[wrPtrReg] <= wrPort.data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtrReg    <= '0;
      rdPtrReg    <= '0;
      countReg    <= '0;
      outValidReg <= 1'b0;
      outDataReg  <= '0;
    end else begin
      wrPtrReg    <= wrFire ? wrPtrReg + 1'b1 : wrPtrReg;
      rdPtrReg    <= loadOut ? rdPtrReg + 1'b1 : rdPtrReg;
      countReg    <= countNext;
      outValidReg <= outValidNext;
      outDataReg  <= loadOut ? mem[rdPtrReg] : outDataReg;
    end
  end

endmodule : siu_fifo
`default_nettype wire

// ==== hw/siu_uart_top.sv ====
// Byte-wide serial transceiver: transmit FIFO, transmitter, oversampling receiver.
`timescale 1ns/1ps
`default_nettype none
module siu_uart_top (
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic [siu_pkg::DATA_BITS-1:0] txWrData,
  input  wire logic                         txWrStrobe,
  output logic                              txWrReady,
  output logic                              txBusy,
  input  wire logic                         fastBaudSelect,
  input  wire logic                         serialLinePinIn,
  output logic                              serialLinePinOut,
  output logic                              serialLinePinOe,
  output logic [siu_pkg::DATA_BITS-1:0]     rxHoldData,
  output logic                              rxHoldFull,
  input  wire logic                         rxHoldRead,
  output logic                              rxOverrun,
  output logic                              rxFrameErr,
  output logic                              txIrq,
  input  wire logic                         txIrqClr,
  output logic                              rxIrq,
  input  wire logic                         rxIrqClr
);
  import siu_pkg::*;

  siu_stream_if #(.WIDTH(FIFO_WIDTH)) txInIf ();
  siu_stream_if #(.WIDTH(FIFO_WIDTH)) txOutIf ();

  // Writes land in the FIFO so firmware may queue bytes while a frame is in flight.
  siu_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wrPort   (txInIf.snk),
    .rdPort   (txOutIf.src)
  );

  assign txInIf.valid = txWrStrobe;
  assign txInIf.data  = txWrData;
  assign txWrReady    = txInIf.ready;

  wire [8:0] baudDiv;
  assign baudDiv = siu_baud_div(fastBaudSelect);

  // ---------------- Transmitter ----------------
  siu_tx_state_t txStateReg;
  siu_tx_state_t txStateNext;
  logic [8:0]    txDivReg;
  logic [3:0]    txPhaseReg;
  logic [2:0]    txBitReg;
  logic [7:0]    txShiftReg;
  logic [7:0]    txShiftNext;
  logic          txIrqReg;
  logic          txLineReg;
  logic          txOeReg;
  wire           txLoad;
  wire           txTick;
  wire           txBitEnd;
  wire           txStopEnter;
  wire           txLineNext;
  wire [8:0]     txDivNext;
  wire [3:0]     txPhaseNext;
  wire [2:0]     txBitNext;

  assign txOutIf.ready = (txStateReg == TX_IDLE);
  assign txLoad        = txOutIf.valid & txOutIf.ready;
  assign txTick        = siu_div_end(txDivReg, baudDiv);
  assign txBitEnd      = txTick & (txPhaseReg == PH_LAST);
  assign txStopEnter   = txBitEnd & (txStateReg == TX_DATA) & (txBitReg == LAST_BIT);
  assign txDivNext     = (txLoad | txTick) ? DIV_RST : txDivReg + 9'h001;
  assign txPhaseNext   = txLoad ? PHASE_RST : (txTick ? txPhaseReg + 4'h1 : txPhaseReg);
  assign txBitNext     = txLoad ? BIT_RST :
                         ((txBitEnd & (txStateReg == TX_DATA)) ? txBitReg + 3'h1 : txBitReg);

  always_comb begin
    txStateNext = txStateReg;
    case (txStateReg)
      TX_IDLE: begin
        if (txLoad) begin
          txStateNext = TX_START;
        end
      end
      TX_START: begin
        if (txBitEnd) begin
          txStateNext = TX_DATA;
        end
      end
      TX_DATA: begin
        if (txStopEnter) begin
          txStateNext = TX_STOP;
        end
      end
      TX_STOP: begin
        if (txBitEnd) begin
          txStateNext = TX_IDLE;
        end
      end
      default: begin
        txStateNext = TX_IDLE;
      end
    endcase
  end

  // Data leave least significant bit first.
  assign txShiftNext = txLoad ? txOutIf.data :
                       (txBitEnd & (txStateReg == TX_DATA)) ? {1'b0, txShiftReg[7:1]} :
                       txShiftReg;

  // The line level is registered from the next state so pin and state change together.
  assign txLineNext = (txStateNext == TX_START) ? START_LEVEL :
                      (txStateNext == TX_DATA)  ? txShiftNext[0] :
                      STOP_LEVEL;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txStateReg <= TX_IDLE;
      txDivReg   <= DIV_RST;
      txPhaseReg <= PHASE_RST;
      txBitReg   <= BIT_RST;
      txShiftReg <= BYTE_RST;
      txLineReg  <= IDLE_LEVEL;
      txOeReg    <= 1'b0;
    end else begin
      txStateReg <= txStateNext;
      txDivReg   <= txDivNext;
      txPhaseReg <= txPhaseNext;
      txBitReg   <= txBitNext;
      txShiftReg <= txShiftNext;
      txLineReg  <= txLineNext;
      txOeReg    <= (txStateNext != TX_IDLE);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txIrqReg <= 1'b0;
    end else begin
      txIrqReg <= txStopEnter | (txIrqReg & ~txIrqClr);
    end
  end

  assign serialLinePinOut = txLineReg;
  assign serialLinePinOe  = txOeReg;
  assign txBusy           = txOeReg | txOutIf.valid;
  assign txIrq            = txIrqReg;

  // ---------------- Receiver ----------------
  // The receiver always listens to the pin, so a transmitted frame is also heard back.
  siu_rx_state_t rxStateReg;
  siu_rx_state_t rxStateNext;
  logic          rxSync1Reg;
  logic          rxSync2Reg;
  logic          rxPrevReg;
  logic          rxCleanReg;
  logic [8:0]    rxDivReg;
  logic [3:0]    rxPhaseReg;
  logic [2:0]    rxBitReg;
  logic [1:0]    rxVoteReg;
  logic [7:0]    rxShiftReg;
  logic [7:0]    rxHoldReg;
  logic          rxFullReg;
  logic          rxIrqReg;
  logic          rxOverrunReg;
  logic          rxFrameErrReg;
  wire           rxStable;
  wire           rxFall;
  wire           rxStart;
  wire           rxTick;
  wire           rxBitEnd;
  wire           rxDecide;
  wire           rxBit;
  wire           rxSpike;
  wire           rxStopSeen;
  wire           rxStore;
  wire           rxBadStop;
  wire [8:0]     rxDivNext;
  wire [3:0]     rxPhaseNext;
  wire [2:0]     rxBitNext;

  // Two agreeing synchronised samples are needed before the clean line moves.
  assign rxStable   = (rxSync2Reg == rxPrevReg);
  assign rxFall     = rxCleanReg & rxStable & ~rxSync2Reg;
  assign rxStart    = (rxStateReg == RX_IDLE) & rxFall;
  assign rxTick     = siu_div_end(rxDivReg, baudDiv);
  assign rxBitEnd   = rxTick & (rxPhaseReg == PH_LAST);
  assign rxDecide   = rxTick & (rxPhaseReg == PH_VOTE_C);
  assign rxBit      = siu_maj3(rxVoteReg[1], rxVoteReg[0], rxCleanReg);
  assign rxSpike    = rxDecide & (rxStateReg == RX_START) & (rxBit != START_LEVEL);
  assign rxStopSeen = rxDecide & (rxStateReg == RX_STOP);
  assign rxStore    = rxStopSeen & (rxBit == STOP_LEVEL);
  assign rxBadStop  = rxStopSeen & (rxBit != STOP_LEVEL);
  assign rxDivNext   = (rxStart | rxTick) ? DIV_RST : rxDivReg + 9'h001;
  assign rxPhaseNext = rxStart ? PHASE_RST : (rxTick ? rxPhaseReg + 4'h1 : rxPhaseReg);
  assign rxBitNext   = rxStart ? BIT_RST :
                       ((rxBitEnd & (rxStateReg == RX_DATA)) ? rxBitReg + 3'h1 : rxBitReg);

  always_comb begin
    rxStateNext = rxStateReg;
    case (rxStateReg)
      RX_IDLE: begin
        if (rxStart) begin
          rxStateNext = RX_START;
        end
      end
      RX_START: begin
        if (rxSpike) begin
          rxStateNext = RX_IDLE;
        end else if (rxBitEnd) begin
          rxStateNext = RX_DATA;
        end
      end
      RX_DATA: begin
        if (rxBitEnd & (rxBitReg == LAST_BIT)) begin
          rxStateNext = RX_STOP;
        end
      end
      RX_STOP: begin
        // Leaving at mid stop bit lets the next start edge be caught on time.
        if (rxStopSeen) begin
          rxStateNext = RX_IDLE;
        end
      end
      default: begin
        rxStateNext = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxSync1Reg <= IDLE_LEVEL;
      rxSync2Reg <= IDLE_LEVEL;
      rxPrevReg  <= IDLE_LEVEL;
      rxCleanReg <= IDLE_LEVEL;
    end else begin
      rxSync1Reg <= serialLinePinIn;
      rxSync2Reg <= rxSync1Reg;
      rxPrevReg  <= rxSync2Reg;
      rxCleanReg <= rxStable ? rxSync2Reg : rxCleanReg;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxStateReg <= RX_IDLE;
      rxDivReg   <= DIV_RST;
      rxPhaseReg <= PHASE_RST;
      rxBitReg   <= BIT_RST;
      rxVoteReg  <= VOTE_RST;
      rxShiftReg <= BYTE_RST;
    end else begin
      rxStateReg <= rxStateNext;
      rxDivReg   <= rxDivNext;
      rxPhaseReg <= rxPhaseNext;
      rxBitReg   <= rxBitNext;
      rxVoteReg[1] <= (rxTick & (rxPhaseReg == PH_VOTE_A)) ? rxCleanReg : rxVoteReg[1];
      rxVoteReg[0] <= (rxTick & (rxPhaseReg == PH_VOTE_B)) ? rxCleanReg : rxVoteReg[0];
      rxShiftReg <= (rxDecide & (rxStateReg == RX_DATA)) ? {rxBit, rxShiftReg[7:1]} :
                    rxShiftReg;
    end
  end

  // A completed byte replaces whatever is held; a read in the same cycle loses to it.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxHoldReg     <= BYTE_RST;
      rxFullReg     <= 1'b0;
      rxOverrunReg  <= 1'b0;
      rxFrameErrReg <= 1'b0;
      rxIrqReg      <= 1'b0;
    end else begin
      rxHoldReg     <= rxStore ? rxShiftReg : rxHoldReg;
      rxFullReg     <= rxStore | (rxFullReg & ~rxHoldRead);
      rxOverrunReg  <= (rxStore & rxFullReg & ~rxHoldRead) | (rxOverrunReg & ~rxHoldRead);
      rxFrameErrReg <= rxBadStop | (rxFrameErrReg & ~rxIrqClr);
      rxIrqReg      <= rxStopSeen | (rxIrqReg & ~rxIrqClr);
    end
  end

  assign rxHoldData = rxHoldReg;
  assign rxHoldFull = rxFullReg;
  assign rxOverrun  = rxOverrunReg;
  assign rxFrameErr = rxFrameErrReg;
  assign rxIrq      = rxIrqReg;

endmodule : siu_uart_top
`default_nettype wire

// ==== dv/siu_host_model.sv ====
// Host-side serial partner: resolves the shared pin and sends or samples frames.
`timescale 1ns/1ps
`default_nettype none
module siu_host_model (
  input  wire logic core_clk,
  input  wire logic devOut,
  input  wire logic devOe,
  output logic      lineLevel
);
  import siu_pkg::*;
  logic hostDrv = IDLE_LEVEL;

  // While the device enables its output its level wins, whatever the host drives.
  assign lineLevel = devOe ? devOut : hostDrv;

  // A glitch index of 0..7 inverts that data bit over its first seven phases only.
  task automatic sendByte(input logic [7:0] b, input int bitClk, input int glitchBit);
    logic [9:0] frame;
    frame = {STOP_LEVEL, b, START_LEVEL};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < bitClk; c++) begin
        @(negedge core_clk);
        hostDrv = frame[i] ^ (i == glitchBit + 1 && c >= 10 && c < 7 * bitClk / 16 - 10);
      end
    end
  endtask : sendByte

  task automatic sendSpike(input int len);
    @(negedge core_clk);
    hostDrv = START_LEVEL;
    repeat (len) @(negedge core_clk);
    hostDrv = IDLE_LEVEL;
  endtask : sendSpike

  // Returns at the middle of the stop bit.
  task automatic recvByte(input int bitClk, output logic [7:0] b, output logic stopLvl);
    int n;
    n = 0;
    while (lineLevel !== START_LEVEL && n < 50000) begin
      @(negedge core_clk);
      n++;
    end
    repeat (bitClk / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitClk) @(negedge core_clk);
      b[i] = lineLevel;
    end
    repeat (bitClk) @(negedge core_clk);
    stopLvl = lineLevel;
  endtask : recvByte
endmodule : siu_host_model
`default_nettype wire

// ==== dv/siu_uart_checker.sv ====
// Concurrent checks on the serial transceiver's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module siu_uart_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic txWrStrobe,
  input wire logic txWrReady,
  input wire logic txBusy,
  input wire logic fastBaudSelect,
  input wire logic serialLinePinOut,
  input wire logic serialLinePinOe,
  input wire logic rxHoldFull,
  input wire logic rxHoldRead,
  input wire logic rxOverrun,
  input wire logic txIrq,
  input wire logic txIrqClr,
  input wire logic rxIrq,
  input wire logic rxIrqClr
);
  int unsigned oeCntReg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) oeCntReg <= 0;
    else if (!serialLinePinOe) oeCntReg <= 0;
    else oeCntReg <= oeCntReg + 1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  idle_high_a: assert property (!serialLinePinOe |-> serialLinePinOut)
    else $error("Line not high while released.");
  tx_launch_a: assert property (txWrStrobe && txWrReady && !txBusy |-> ##3 (serialLinePinOe && !serialLinePinOut))
    else $error("Write did not launch a start bit.");
  start_low_a: assert property ($rose(serialLinePinOe) |-> !serialLinePinOut [*8])
    else $error("Frame did not open with a low start bit.");
  frame_len_a: assert property ($fell(serialLinePinOe) |-> oeCntReg == (fastBaudSelect ? 10400 : 41600))
    else $error("Frame length does not match the baud rate.");
  tx_flag_stop_a: assert property ($rose(txIrq) |-> serialLinePinOe && serialLinePinOut)
    else $error("Transmit flag set outside the stop bit.");
  tx_flag_hold_a: assert property (txIrq && !txIrqClr |=> txIrq)
    else $error("Transmit flag dropped without a clear.");
  rx_flag_hold_a: assert property (rxIrq && !rxIrqClr |=> rxIrq)
    else $error("Receive flag dropped without a clear.");
  hold_with_irq_a: assert property ($rose(rxHoldFull) |-> rxIrq)
    else $error("Byte held without a receive flag.");
  overrun_cause_a: assert property ($rose(rxOverrun) |-> $past(rxHoldFull))
    else $error("Overrun without a held byte.");
  read_clear_a: assert property (rxHoldRead |=> !rxOverrun)
    else $error("Read did not clear the overrun flag.");

  cover property ($rose(txIrq));
  cover property ($rose(rxOverrun));
  cover property (!txWrReady);
endmodule : siu_uart_checker

bind siu_uart_top siu_uart_checker i_siu_uart_checker (
  .core_clk(core_clk), .arst_n(arst_n), .txWrStrobe(txWrStrobe), .txWrReady(txWrReady),
  .txBusy(txBusy), .fastBaudSelect(fastBaudSelect), .serialLinePinOut(serialLinePinOut),
  .serialLinePinOe(serialLinePinOe), .rxHoldFull(rxHoldFull), .rxHoldRead(rxHoldRead),
  .rxOverrun(rxOverrun), .txIrq(txIrq), .txIrqClr(txIrqClr), .rxIrq(rxIrq), .rxIrqClr(rxIrqClr));
`default_nettype wire

// ==== dv/siu_uart_top_tb.sv ====
// Self-checking bench for the serial transceiver against a host model on the pin.
`timescale 1ns/1ps
`default_nettype none
module siu_uart_top_tb;
  import siu_pkg::*;
  localparam int BIT_FAST = int'(DIV_FAST) * OVERSAMPLE;
  localparam int BIT_SLOW = int'(DIV_SLOW) * OVERSAMPLE;
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] txWrData = 8'h00;
  logic       txWrStrobe = 1'b0;
  logic       fastBaudSelect = 1'b1;
  logic       rxHoldRead = 1'b0;
  logic       txIrqClr = 1'b0;
  logic       rxIrqClr = 1'b0;
  wire logic  txWrReady, txBusy, lineIn, pinOut, pinOe, rxHoldFull, rxOverrun, txIrq, rxIrq;
  wire logic  rxFrameErr;
  wire logic [7:0] rxHoldData;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  always #50 core_clk = ~core_clk;

  siu_uart_top i_siu_uart_top (.core_clk(core_clk), .arst_n(arst_n), .txWrData(txWrData),
    .txWrStrobe(txWrStrobe), .txWrReady(txWrReady), .txBusy(txBusy),
    .fastBaudSelect(fastBaudSelect), .serialLinePinIn(lineIn), .serialLinePinOut(pinOut),
    .serialLinePinOe(pinOe), .rxHoldData(rxHoldData), .rxHoldFull(rxHoldFull),
    .rxHoldRead(rxHoldRead), .rxOverrun(rxOverrun), .rxFrameErr(rxFrameErr), .txIrq(txIrq),
    .txIrqClr(txIrqClr), .rxIrq(rxIrq), .rxIrqClr(rxIrqClr));
  siu_host_model i_siu_host_model (.core_clk(core_clk), .devOut(pinOut), .devOe(pinOe),
    .lineLevel(lineIn));

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // The whole run needs about 70000 cycles, so this ceiling only trips on a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic do_reset;
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    check(pinOe === 1'b0 && pinOut === 1'b1 && txWrReady === 1'b1, "reset line state");
    check(txIrq === 1'b0 && rxIrq === 1'b0 && rxHoldFull === 1'b0, "reset flags");
  endtask : do_reset

  task automatic write_byte(input logic [7:0] b);
    @(negedge core_clk);
    txWrData = b;
    txWrStrobe = 1'b1;
    @(negedge core_clk);
    txWrStrobe = 1'b0;
  endtask : write_byte

  task automatic pulse(input logic t, input logic r, input logic h);
    @(negedge core_clk);
    txIrqClr = t;
    rxIrqClr = r;
    rxHoldRead = h;
    @(negedge core_clk);
    {txIrqClr, rxIrqClr, rxHoldRead} = 3'h0;
  endtask : pulse

  // The receiver hears the device's own frame on the shared pin.
  task automatic test_tx;
    logic [7:0] got;
    logic       stopLvl;
    write_byte(8'hA5);
    check(txIrq === 1'b0, "transmit flag early");
    i_siu_host_model.recvByte(BIT_FAST, got, stopLvl);
    check(got === 8'hA5 && stopLvl === 1'b1, "sent frame content");
    check(txIrq === 1'b1 && pinOe === 1'b1, "flag during stop bit");
    repeat (600) @(negedge core_clk);
    check(pinOe === 1'b0 && pinOut === 1'b1 && txIrq === 1'b1, "idle after frame");
    check(rxIrq === 1'b1 && rxHoldData === 8'hA5, "echo received");
    pulse(1'b1, 1'b0, 1'b0);
    check(txIrq === 1'b0 && rxIrq === 1'b1, "separate flags");
    pulse(1'b0, 1'b1, 1'b1);
  endtask : test_tx

  task automatic test_spike;
    i_siu_host_model.sendSpike(3 * int'(DIV_FAST));
    repeat (2000) @(negedge core_clk);
    check(rxIrq === 1'b0 && rxHoldFull === 1'b0, "spike taken as frame");
  endtask : test_spike

  task automatic test_rx(input logic [7:0] b, input int glitchBit);
    i_siu_host_model.sendByte(b, BIT_FAST, glitchBit);
    check(pinOe === 1'b0 && pinOut === 1'b1, "pin released while receiving");
    check(rxIrq === 1'b1 && rxHoldFull === 1'b1, "receive flags");
    check(rxHoldData === b && rxOverrun === 1'b0, "received byte");
    pulse(1'b0, 1'b1, 1'b1);
    check(rxIrq === 1'b0 && rxHoldFull === 1'b0, "flags cleared");
  endtask : test_rx

  task automatic test_overrun;
    i_siu_host_model.sendByte(8'h11, BIT_FAST, 99);
    check(rxHoldData === 8'h11 && rxHoldFull === 1'b1, "first byte held");
    i_siu_host_model.sendByte(8'hEE, BIT_FAST, 99);
    check(rxHoldData === 8'hEE && rxOverrun === 1'b1, "held byte replaced");
    pulse(1'b0, 1'b1, 1'b1);
    check(rxOverrun === 1'b0, "overrun cleared by read");
  endtask : test_overrun

  // Ten bit times of low line: every data bit reads zero and the stop bit is low.
  task automatic test_framing;
    i_siu_host_model.sendSpike(10 * BIT_FAST);
    repeat (20) @(negedge core_clk);
    check(rxFrameErr === 1'b1 && rxIrq === 1'b1, "bad stop bit flagged");
    check(rxHoldFull === 1'b0 && rxHoldData === 8'hEE, "bad frame stored");
    pulse(1'b0, 1'b1, 1'b0);
    check(rxFrameErr === 1'b0 && rxIrq === 1'b0, "framing flags not cleared");
  endtask : test_framing

  // Thirty-two FIFO entries, the output stage and the transmitter itself hold a byte each.
  task automatic test_fifo;
    int n;
    n = 0;
    @(negedge core_clk);
    txWrStrobe = 1'b1;
    while (txWrReady === 1'b1 && n < 40) begin
      txWrData = 8'(n);
      n++;
      @(negedge core_clk);
    end
    @(negedge core_clk);
    check(txWrReady === 1'b0 && txBusy === 1'b1, "refused while full");
    txWrStrobe = 1'b0;
    check(n === FIFO_DEPTH + 2, "bytes accepted");
    do_reset();
  endtask : test_fifo

  task automatic test_slow;
    int n;
    n = 0;
    fastBaudSelect = 1'b0;
    write_byte(8'hFF);
    while (pinOe !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    while (pinOut === 1'b0 && n < 9000) begin
      @(negedge core_clk);
      n++;
    end
    check(n === BIT_SLOW, "slow start bit length");
    fastBaudSelect = 1'b1;
    do_reset();
  endtask : test_slow

  initial begin
    do_reset();
    test_tx();
    test_spike();
    test_rx(8'h3C, 99);
    test_rx(8'h96, 2);
    test_overrun();
    test_framing();
    test_fifo();
    test_slow();
    end_of_test();
  end
endmodule : siu_uart_top_tb
`default_nettype wire
